//--- design/tapp_defs.svh
// Constants of the test access port: instruction codes, widths, reset values
`ifndef TAPP_DEFS_SVH
`define TAPP_DEFS_SVH

// Instruction register
`define TAPP_IR_W 3
`define TAPP_IR_IDCODE 3'h1
`define TAPP_IR_BYPASS 3'h7
// Fixed pattern loaded into the instruction shifter on capture
`define TAPP_IR_CAPTURE 3'h1

// Data register shifter, wide enough for the identification word
`define TAPP_DR_W 32
// Identification word: value is arbitrary, bit 0 must stay set
`define TAPP_IDCODE_VALUE 32'h0a5c_3001
`define TAPP_DR_RESET 32'h0000_0000

// Pin synchroniser depth and reset levels
`define TAPP_SYNC_STAGES 3
// All three synced levels idle high (pull-ups, controller in reset), so
// resetting to one keeps a false low from arming identification mode
`define TAPP_SYNC_RESET 1'h1

`endif

//--- design/tapp_pkg.sv
// Types shared by the test access port design
package tapp_pkg;

  typedef enum logic [3:0] {
    TAPP_TEST_LOGIC_RESET,
    TAPP_RUN_TEST_IDLE,
    TAPP_SELECT_DR,
    TAPP_CAPTURE_DR,
    TAPP_SHIFT_DR,
    TAPP_EXIT1_DR,
    TAPP_PAUSE_DR,
    TAPP_EXIT2_DR,
    TAPP_UPDATE_DR,
    TAPP_SELECT_IR,
    TAPP_CAPTURE_IR,
    TAPP_SHIFT_IR,
    TAPP_EXIT1_IR,
    TAPP_PAUSE_IR,
    TAPP_EXIT2_IR,
    TAPP_UPDATE_IR
  } tapp_state_t;

endpackage

//--- design/tapp_sync.sv
// Three-stage level synchroniser with agreement filter
`timescale 1ns/1ps
`include "tapp_defs.svh"

module tapp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Asynchronous levels in, filtered levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;

      // First stage feeds only the second stage
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          s1_q <= `TAPP_SYNC_RESET;
          s2_q <= `TAPP_SYNC_RESET;
          s3_q <= `TAPP_SYNC_RESET;
        end else begin
          s1_q <= async_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end

      // A change counts once stages two and three agree
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          lvl_q <= `TAPP_SYNC_RESET;
        end else if (s2_q == s3_q) begin
          lvl_q <= s3_q;
        end
      end

      assign level_out[i] = lvl_q;
    end
  endgenerate

endmodule

//--- design/tapp_top.sv
// Boundary-scan test access port and digital I/O isolation control
`timescale 1ns/1ps
`include "tapp_defs.svh"

module tapp_top (
  // System clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Test port pins
  input wire logic tap_clk,
  input wire logic tap_reset_n,
  input wire logic tap_mode_sel,
  input wire logic tap_serial_in,
  output logic tap_serial_out,
  output logic tap_serial_oe_out,
  // Digital I/O isolation
  input wire logic digital_io_enable,
  output logic io_hiz_out,
  // Device mode, system clock domain
  output logic id_mode_out,
  output logic tap_in_reset_out
);

  import tapp_pkg::*;

  // Test clock domain reset: pin low acts at once, without the clock
  logic tap_rst;
  assign tap_rst = rst_in | ~tap_reset_n;

  tapp_state_t state_q;
  tapp_state_t state_d;
  logic [`TAPP_IR_W-1:0] ir_q;
  logic [`TAPP_IR_W-1:0] ir_sh_q;
  logic [`TAPP_DR_W-1:0] dr_sh_q;
  logic tdo_q;
  logic tdo_oe_q;
  logic tlr_q;

  // Controller next state from the mode select level
  always_comb begin
    state_d = state_q;
    case (state_q)
      TAPP_TEST_LOGIC_RESET: begin
        state_d = tap_mode_sel ? TAPP_TEST_LOGIC_RESET : TAPP_RUN_TEST_IDLE;
      end
      TAPP_RUN_TEST_IDLE: begin
        state_d = tap_mode_sel ? TAPP_SELECT_DR : TAPP_RUN_TEST_IDLE;
      end
      TAPP_SELECT_DR: begin
        state_d = tap_mode_sel ? TAPP_SELECT_IR : TAPP_CAPTURE_DR;
      end
      TAPP_CAPTURE_DR: begin
        state_d = tap_mode_sel ? TAPP_EXIT1_DR : TAPP_SHIFT_DR;
      end
      TAPP_SHIFT_DR: begin
        state_d = tap_mode_sel ? TAPP_EXIT1_DR : TAPP_SHIFT_DR;
      end
      TAPP_EXIT1_DR: begin
        state_d = tap_mode_sel ? TAPP_UPDATE_DR : TAPP_PAUSE_DR;
      end
      TAPP_PAUSE_DR: begin
        state_d = tap_mode_sel ? TAPP_EXIT2_DR : TAPP_PAUSE_DR;
      end
      TAPP_EXIT2_DR: begin
        state_d = tap_mode_sel ? TAPP_UPDATE_DR : TAPP_SHIFT_DR;
      end
      TAPP_UPDATE_DR: begin
        state_d = tap_mode_sel ? TAPP_SELECT_DR : TAPP_RUN_TEST_IDLE;
      end
      TAPP_SELECT_IR: begin
        state_d = tap_mode_sel ? TAPP_TEST_LOGIC_RESET : TAPP_CAPTURE_IR;
      end
      TAPP_CAPTURE_IR: begin
        state_d = tap_mode_sel ? TAPP_EXIT1_IR : TAPP_SHIFT_IR;
      end
      TAPP_SHIFT_IR: begin
        state_d = tap_mode_sel ? TAPP_EXIT1_IR : TAPP_SHIFT_IR;
      end
      TAPP_EXIT1_IR: begin
        state_d = tap_mode_sel ? TAPP_UPDATE_IR : TAPP_PAUSE_IR;
      end
      TAPP_PAUSE_IR: begin
        state_d = tap_mode_sel ? TAPP_EXIT2_IR : TAPP_PAUSE_IR;
      end
      TAPP_EXIT2_IR: begin
        state_d = tap_mode_sel ? TAPP_UPDATE_IR : TAPP_SHIFT_IR;
      end
      TAPP_UPDATE_IR: begin
        state_d = tap_mode_sel ? TAPP_SELECT_DR : TAPP_RUN_TEST_IDLE;
      end
      default: begin
        state_d = TAPP_TEST_LOGIC_RESET;
      end
    endcase
  end

  always_ff @(posedge tap_clk or posedge tap_rst) begin
    if (tap_rst) begin
      state_q <= TAPP_TEST_LOGIC_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Instruction shifter and latched instruction
  always_ff @(posedge tap_clk or posedge tap_rst) begin
    if (tap_rst) begin
      ir_sh_q <= `TAPP_IR_CAPTURE;
    end else if (state_q == TAPP_CAPTURE_IR) begin
      ir_sh_q <= `TAPP_IR_CAPTURE;
    end else if (state_q == TAPP_SHIFT_IR) begin
      ir_sh_q <= {tap_serial_in, ir_sh_q[`TAPP_IR_W-1:1]};
    end
  end

  // Identification is selected after every controller reset
  always_ff @(posedge tap_clk or posedge tap_rst) begin
    if (tap_rst) begin
      ir_q <= `TAPP_IR_IDCODE;
    end else if (state_q == TAPP_TEST_LOGIC_RESET) begin
      ir_q <= `TAPP_IR_IDCODE;
    end else if (state_q == TAPP_UPDATE_IR) begin
      ir_q <= ir_sh_q;
    end
  end

  // Data shifter; anything but identification acts as one-bit bypass
  always_ff @(posedge tap_clk or posedge tap_rst) begin
    if (tap_rst) begin
      dr_sh_q <= `TAPP_DR_RESET;
    end else if (state_q == TAPP_CAPTURE_DR) begin
      if (ir_q == `TAPP_IR_IDCODE) begin
        dr_sh_q <= `TAPP_IDCODE_VALUE;
      end else begin
        dr_sh_q <= `TAPP_DR_RESET;
      end
    end else if (state_q == TAPP_SHIFT_DR) begin
      if (ir_q == `TAPP_IR_IDCODE) begin
        dr_sh_q <= {tap_serial_in, dr_sh_q[`TAPP_DR_W-1:1]};
      end else begin
        dr_sh_q[0] <= tap_serial_in;
      end
    end
  end

  // Output changes half a cycle ahead of the tester's rising sample
  always_ff @(negedge tap_clk or posedge tap_rst) begin
    if (tap_rst) begin
      tdo_q <= 1'h0;
      tdo_oe_q <= 1'h0;
    end else begin
      tdo_oe_q <= (state_q == TAPP_SHIFT_IR) ||
                  (state_q == TAPP_SHIFT_DR);
      if (state_q == TAPP_SHIFT_IR) begin
        tdo_q <= ir_sh_q[0];
      end else if (state_q == TAPP_SHIFT_DR) begin
        tdo_q <= dr_sh_q[0];
      end
    end
  end

  assign tap_serial_out = tdo_q;
  assign tap_serial_oe_out = tdo_oe_q;

  // Controller reset level handed to the system domain
  always_ff @(posedge tap_clk or posedge tap_rst) begin
    if (tap_rst) begin
      tlr_q <= 1'h1;
    end else begin
      tlr_q <= (state_d == TAPP_TEST_LOGIC_RESET);
    end
  end

  // Pins and test-domain level into the system clock domain
  logic [2:0] sync_lvl;

  tapp_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({tlr_q, digital_io_enable, tap_reset_n}),
    .level_out(sync_lvl)
  );

  logic trst_lvl;
  logic ioen_lvl;
  assign trst_lvl = sync_lvl[0];
  assign ioen_lvl = sync_lvl[1];

  // Identification needs a low seen before the rising edge, so a pin
  // left floating high from power-up never enters it
  logic seen_low_q;
  logic id_mode_q;
  logic hiz_q;
  logic in_reset_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      seen_low_q <= 1'h0;
    end else if (!trst_lvl) begin
      seen_low_q <= 1'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      id_mode_q <= 1'h0;
    end else if (!trst_lvl) begin
      id_mode_q <= 1'h0;
    end else if (seen_low_q) begin
      id_mode_q <= 1'h1;
    end
  end

  // Digital pins float only while both controls are low
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hiz_q <= 1'h0;
    end else begin
      hiz_q <= ~ioen_lvl & ~trst_lvl;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      in_reset_q <= 1'h1;
    end else begin
      in_reset_q <= sync_lvl[2];
    end
  end

  assign id_mode_out = id_mode_q;
  assign io_hiz_out = hiz_q;
  assign tap_in_reset_out = in_reset_q;

endmodule

//--- dv/tapp_top_assertions.sv
// Concurrent checks on the test port pins
`timescale 1ns/1ps
module tapp_top_assertions (
  // Clocks and resets
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tap_clk,
  input wire logic tap_reset_n,
  // Watched outputs and levels
  input wire logic tap_serial_out,
  input wire logic tap_serial_oe_out,
  input wire logic digital_io_enable,
  input wire logic io_hiz_out,
  input wire logic id_mode_out,
  input wire logic tap_in_reset_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Six samples cover three sync flops, agreement and output flop
  sequence low_s; !tap_reset_n [*6]; endsequence
  sequence high_s; tap_reset_n [*6]; endsequence
  // A test clock half spans three samples, so no fall slips past
  sequence tck_hi_s; tap_clk && $past(tap_clk) && tap_reset_n; endsequence
  trst_quiet_a: assert property (!tap_reset_n |-> !tap_serial_oe_out)
    else $error("oe set in test reset");
  tlr_seen_a: assert property (low_s |-> tap_in_reset_out)
    else $error("no reset state");
  id_enter_a: assert property (low_s ##1 high_s |-> id_mode_out)
    else $error("id mode missed");
  id_leave_a: assert property (low_s |-> !id_mode_out)
    else $error("id mode kept");
  hiz_on_a: assert property (
    (!tap_reset_n && !digital_io_enable) [*6] |-> io_hiz_out)
    else $error("pins not isolated");
  hiz_off_a: assert property (digital_io_enable [*6] |-> !io_hiz_out)
    else $error("pins isolated");
  out_hold_a: assert property (tck_hi_s |->
    $stable(tap_serial_out) && $stable(tap_serial_oe_out))
    else $error("out moved off falling edge");
  oe_shift_a: assert property (tap_serial_oe_out |-> !tap_in_reset_out)
    else $error("oe outside shift");
endmodule

bind tapp_top tapp_top_assertions chk (.clk_in(clk_in), .rst_in(rst_in),
  .tap_clk(tap_clk), .tap_reset_n(tap_reset_n),
  .tap_serial_out(tap_serial_out), .tap_serial_oe_out(tap_serial_oe_out),
  .digital_io_enable(digital_io_enable), .io_hiz_out(io_hiz_out),
  .id_mode_out(id_mode_out), .tap_in_reset_out(tap_in_reset_out));

//--- dv/tapp_tester.sv
// Boundary-scan tester model driving the test port pins
`timescale 1ns/1ps
module tapp_tester (
  // Pins towards the device
  output logic tap_clk,
  output logic tap_reset_n,
  output logic tap_mode_sel,
  output logic tap_serial_in,
  input wire logic tap_serial_out
);
  initial begin
    tap_clk = 1'h0;
    tap_reset_n = 1'h0;
    tap_mode_sel = 1'h1;
    tap_serial_in = 1'h1;
  end
  task automatic set_reset(input logic v);
    tap_reset_n = v;
  endtask
  // One 64 ns period; clock stands still between steps
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tap_mode_sel = tms;
    tap_serial_in = tdi;
    #32;
    tdo = tap_serial_out;
    tap_clk = 1'h1;
    // Released lines fall back to their pull-up level once sampled, well
    // away from the next step driving them again
    #2;
    tap_mode_sel = 1'h1;
    tap_serial_in = 1'h1;
    #30;
    tap_clk = 1'h0;
  endtask
endmodule

//--- dv/tapp_top_tb.sv
// Self-checking bench for the test access port
`timescale 1ns/1ps
`include "tapp_defs.svh"
module tapp_top_tb;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic digital_io_enable = 1'h0;
  logic tap_clk, tap_reset_n, tap_mode_sel, tap_serial_in, tap_serial_out;
  logic tap_serial_oe_out, io_hiz_out, id_mode_out, tap_in_reset_out;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] got;
  // Rows: test reset, enable, expected high-Z, expected id mode
  logic [3:0] rows [5] = '{4'b0010, 4'b0100, 4'b1101, 4'b1001, 4'b0010};
  always #5 clk_in = ~clk_in;
  tapp_top dut (.clk_in(clk_in), .rst_in(rst_in), .tap_clk(tap_clk),
    .tap_reset_n(tap_reset_n), .tap_mode_sel(tap_mode_sel),
    .tap_serial_in(tap_serial_in), .tap_serial_out(tap_serial_out),
    .tap_serial_oe_out(tap_serial_oe_out),
    .digital_io_enable(digital_io_enable), .io_hiz_out(io_hiz_out),
    .id_mode_out(id_mode_out), .tap_in_reset_out(tap_in_reset_out));
  tapp_tester tester (.tap_clk(tap_clk), .tap_reset_n(tap_reset_n),
    .tap_mode_sel(tap_mode_sel), .tap_serial_in(tap_serial_in),
    .tap_serial_out(tap_serial_out));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Mode and data bits go LSB first; data out gathered LSB first
  task automatic shift(input int n, input logic [31:0] tms,
      input logic [31:0] tdi);
    logic b;
    got = '0;
    for (int i = 0; i < n; i++) begin
      tester.step(tms[i], tdi[i], b);
      got[i] = b;
    end
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    #1 rst_in = 1'h0;
    repeat (8) @(posedge clk_in);
    #1 chk(tap_in_reset_out, 1'h1);
    chk(tap_serial_oe_out, 1'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      tester.set_reset(rows[i][3]);
      digital_io_enable = rows[i][2];
      repeat (8) @(posedge clk_in);
      #1 chk(io_hiz_out, rows[i][1]);
      chk(id_mode_out, rows[i][0]);
    end
    $display("isolation table done");
    digital_io_enable = 1'h1;
    tester.set_reset(1'h1);
    shift(4, 32'h2, 32'hf);
    shift(32, 32'h8000_0000, 32'hffff_ffff);
    chk(got, `TAPP_IDCODE_VALUE);
    shift(6, 32'hd, 32'hff);
    shift(3, 32'h4, 32'(`TAPP_IR_BYPASS));
    chk(got, 32'(`TAPP_IR_CAPTURE));
    shift(5, 32'h5, 32'hff);
    // Bypass captures 0, then echoes data in one bit late
    shift(4, 32'h0, 32'hd);
    chk(got, 32'ha);
    chk(tap_serial_oe_out, 1'h1);
    $display("scan test done");
    tester.set_reset(1'h0);
    #1 chk(tap_serial_oe_out, 1'h0);
    repeat (8) @(posedge clk_in);
    #1 chk(tap_in_reset_out, 1'h1);
    chk(id_mode_out, 1'h0);
    $display("abort test done");
    // Test reset left high through a system reset must not arm id mode
    tester.set_reset(1'h1);
    rst_in = 1'h1;
    repeat (4) @(posedge clk_in);
    #1 rst_in = 1'h0;
    repeat (8) @(posedge clk_in);
    #1 chk(id_mode_out, 1'h0);
    chk(io_hiz_out, 1'h0);
    chk(tap_in_reset_out, 1'h1);
    $display("floating reset test done");
    test_done();
  end
endmodule
